/* File: design/slc_regs.sv */
// switch link control and status registers behind an ahb-lite slave
`timescale 1ns/1ps
module slc_regs (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    // ahb-lite slave
    input  wire logic                                   hsel,
    input  wire logic [31:0]                            haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic [31:0]                            hwdata,
    input  wire logic                                   hready,
    output logic      [31:0]                            hrdata,
    output logic                                        hreadyout,
    output logic                                        hresp,
    // debug
    input  wire slc_pkg::slc_halt_t                     halt_evt,
    output logic      [1:0]                             debug_origin,
    // link status
    input  wire slc_pkg::slc_lstat_t [slc_pkg::SLC_LINKS-1:0] link_stat,
    input  wire slc_pkg::slc_lstat_t [slc_pkg::SLC_LINKS-1:0] processor_link_stat,
    input  wire slc_pkg::slc_levt_t  [slc_pkg::SLC_LINKS-1:0] link_evt,
    // link controls
    output slc_pkg::slc_lctl_t   [slc_pkg::SLC_LINKS-1:0]    link_ctl,
    output logic      [slc_pkg::SLC_LINKS-1:0][1:0]          processor_link_net,
    output logic      [slc_pkg::SLC_LINKS-1:0]               link_link_greeting_token,
    output logic      [slc_pkg::SLC_LINKS-1:0]               link_rx_reset,
    output slc_pkg::slc_static_t [slc_pkg::SLC_LINKS-1:0]    static_fwd
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    slc_pkg::slc_state_t               q_r;         // registered state
    slc_pkg::slc_state_t               q_nxt;       // next state
    logic                              take;        // address phase accepted
    logic                              wr_ok;       // data phase write lands
    logic [slc_pkg::SLC_LINKS-1:0]     cmd_link_greeting_token;   // greeting command this cycle
    logic [slc_pkg::SLC_LINKS-1:0]     cmd_rxrst;   // receiver reset command this cycle

    // ------------------------------------------------------------------
    // read mux: assembles one register word from state and live status
    // ------------------------------------------------------------------
    function automatic logic [31:0] rd_word(input slc_pkg::slc_state_t s, input logic [7:0] idx,
                                            input slc_pkg::slc_lstat_t [slc_pkg::SLC_LINKS-1:0] ls,
                                            input slc_pkg::slc_lstat_t [slc_pkg::SLC_LINKS-1:0] ps);
        logic [31:0] w;
        w = slc_pkg::SLC_RD_RESET;                  // unmapped and reserved read zero
        if (idx == slc_pkg::SLC_IDX_LOCK) begin
            w[slc_pkg::SLC_LOCK_BIT] = s.lock;
        end
        if (idx == slc_pkg::SLC_IDX_DBG) begin
            w[1:0] = s.dbg;
        end
        for (int i = 0; i < slc_pkg::SLC_LINKS; i++) begin
            if (idx == slc_pkg::SLC_IDX_LSTAT + 8'(i)) begin
                w[slc_pkg::SLC_KIND_LSB +: 2] = ls[i].src_kind;
                w[slc_pkg::SLC_DEST_LSB +: 8] = ls[i].dest;
                w[slc_pkg::SLC_DIR_LSB +: 4]  = s.dir[i];
                w[slc_pkg::SLC_NET_LSB +: 2]  = s.lnet[i];
                w[slc_pkg::SLC_JUNK_BIT]      = ls[i].junk;
                w[slc_pkg::SLC_DBUSY_BIT]     = ls[i].dst_busy;
                w[slc_pkg::SLC_SBUSY_BIT]     = ls[i].src_busy;
            end
            if (idx == slc_pkg::SLC_IDX_PSTAT + 8'(i)) begin
                // same fields, bits 15:6 stay zero: no direction here
                w[slc_pkg::SLC_KIND_LSB +: 2] = ps[i].src_kind;
                w[slc_pkg::SLC_DEST_LSB +: 8] = ps[i].dest;
                w[slc_pkg::SLC_NET_LSB +: 2]  = s.pnet[i];
                w[slc_pkg::SLC_JUNK_BIT]      = ps[i].junk;
                w[slc_pkg::SLC_DBUSY_BIT]     = ps[i].dst_busy;
                w[slc_pkg::SLC_SBUSY_BIT]     = ps[i].src_busy;
            end
            if (idx == slc_pkg::SLC_IDX_LCFG + 8'(i)) begin
                // command bits 24 and 23 always read zero
                w[slc_pkg::SLC_EN_BIT]         = s.cfg[i].en;
                w[slc_pkg::SLC_FIVE_BIT]       = s.cfg[i].five;
                w[slc_pkg::SLC_ERR_BIT]        = s.cfg[i].err;
                w[slc_pkg::SLC_ISS_BIT]        = s.cfg[i].issued;
                w[slc_pkg::SLC_HELD_BIT]       = s.cfg[i].held;
                w[slc_pkg::SLC_SYM_LSB +: 11]  = s.cfg[i].sym_gap;
                w[slc_pkg::SLC_TOK_LSB +: 11]  = s.cfg[i].tok_gap;
            end
            if (idx == slc_pkg::SLC_IDX_STAT + 8'(i)) begin
                w[slc_pkg::SLC_SEN_BIT]       = s.stc[i].en;
                w[slc_pkg::SLC_PROC_BIT]      = s.stc[i].proc;
                w[slc_pkg::SLC_CHE_LSB +: 5]  = s.stc[i].chanend;
            end
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // reads take one wait state so hrdata can come straight from a flop;
    // writes complete with no wait state
    always_comb begin
        q_nxt     = q_r;
        take      = hsel && htrans[1] && hready;
        // lock register itself stays writable, otherwise a lock could never be undone
        wr_ok     = q_r.a_wr && hready && (!q_r.lock || q_r.a_idx == slc_pkg::SLC_IDX_LOCK);
        cmd_link_greeting_token = '0;
        cmd_rxrst = '0;

        // address phase capture
        if (hready) begin
            q_nxt.a_wr  = take && hwrite;
            q_nxt.a_rd  = take && !hwrite;
            q_nxt.a_idx = haddr[9:2];
        end
        // read data phase: one wait, then data from the flop
        if (q_r.a_rd) begin
            q_nxt.hrdata = rd_word(q_r, q_r.a_idx, link_stat, processor_link_stat);
            q_nxt.hready = 1'b1;
            q_nxt.a_rd   = 1'b0;
        end else begin
            q_nxt.hready = !(take && !hwrite);
        end

        // software writes
        if (wr_ok) begin
            if (q_r.a_idx == slc_pkg::SLC_IDX_LOCK) begin
                q_nxt.lock = hwdata[slc_pkg::SLC_LOCK_BIT];
            end
            if (q_r.a_idx == slc_pkg::SLC_IDX_DBG) begin
                q_nxt.dbg = hwdata[1:0];
            end
            for (int i = 0; i < slc_pkg::SLC_LINKS; i++) begin
                if (q_r.a_idx == slc_pkg::SLC_IDX_LSTAT + 8'(i)) begin
                    q_nxt.dir[i]  = hwdata[slc_pkg::SLC_DIR_LSB +: 4];
                    q_nxt.lnet[i] = hwdata[slc_pkg::SLC_NET_LSB +: 2];
                end
                if (q_r.a_idx == slc_pkg::SLC_IDX_PSTAT + 8'(i)) begin
                    q_nxt.pnet[i] = hwdata[slc_pkg::SLC_NET_LSB +: 2];
                end
                if (q_r.a_idx == slc_pkg::SLC_IDX_LCFG + 8'(i)) begin
                    q_nxt.cfg[i].en      = hwdata[slc_pkg::SLC_EN_BIT];
                    q_nxt.cfg[i].five    = hwdata[slc_pkg::SLC_FIVE_BIT];
                    q_nxt.cfg[i].sym_gap = hwdata[slc_pkg::SLC_SYM_LSB +: 11];
                    q_nxt.cfg[i].tok_gap = hwdata[slc_pkg::SLC_TOK_LSB +: 11];
                    cmd_link_greeting_token[i]         = hwdata[slc_pkg::SLC_LINK_GREETING_TOKEN_BIT];
                    cmd_rxrst[i]         = hwdata[slc_pkg::SLC_RXRST_BIT];
                end
                if (q_r.a_idx == slc_pkg::SLC_IDX_STAT + 8'(i)) begin
                    q_nxt.stc[i].en      = hwdata[slc_pkg::SLC_SEN_BIT];
                    q_nxt.stc[i].proc    = hwdata[slc_pkg::SLC_PROC_BIT];
                    q_nxt.stc[i].chanend = hwdata[slc_pkg::SLC_CHE_LSB +: 5];
                end
            end
        end

        // halt event origin: a hardware event beats a same-cycle write
        if (halt_evt.core_one || halt_evt.core_zero) begin
            q_nxt.dbg = {halt_evt.core_one, halt_evt.core_zero};
        end

        // per-link flags and command pulses
        for (int i = 0; i < slc_pkg::SLC_LINKS; i++) begin
            q_nxt.link_greeting_token[i]  = cmd_link_greeting_token[i];
            q_nxt.rx_rst[i] = cmd_rxrst[i];
            // error is sticky until a receiver reset; a new fault wins
            if (link_evt[i].ovf || link_evt[i].bad_tok) begin
                q_nxt.cfg[i].err = 1'b1;
            end else if (cmd_rxrst[i]) begin
                q_nxt.cfg[i].err = 1'b0;
            end
            // own credit: granted by remote, dropped by greeting or disable
            if (link_evt[i].cred_in) begin
                q_nxt.cfg[i].held = 1'b1;
            end else if (cmd_link_greeting_token[i] || !q_nxt.cfg[i].en) begin
                q_nxt.cfg[i].held = 1'b0;
            end
            // credit we issued: dropped by receiver reset or disable
            if (link_evt[i].cred_out) begin
                q_nxt.cfg[i].issued = 1'b1;
            end else if (cmd_rxrst[i] || !q_nxt.cfg[i].en) begin
                q_nxt.cfg[i].issued = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r        <= '0;
            q_r.hready <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from state flops except hresp, which is tied to okay
    // ------------------------------------------------------------------
    assign hrdata        = q_r.hrdata;
    assign hreadyout     = q_r.hready;
    assign hresp         = 1'b0;          // always okay
    assign debug_origin  = q_r.dbg;
    assign processor_link_net     = q_r.pnet;
    assign link_link_greeting_token    = q_r.link_greeting_token;     // one-cycle greeting request
    assign link_rx_reset = q_r.rx_rst;    // one-cycle receiver reset

    // link controls and static routing reorder
    for (genvar g = 0; g < slc_pkg::SLC_LINKS; g++) begin : g_out
        assign link_ctl[g].en      = q_r.cfg[g].en;
        assign link_ctl[g].five    = q_r.cfg[g].five;
        assign link_ctl[g].dir     = q_r.dir[g];
        assign link_ctl[g].net     = q_r.lnet[g];
        assign link_ctl[g].sym_gap = q_r.cfg[g].sym_gap;
        assign link_ctl[g].tok_gap = q_r.cfg[g].tok_gap;
        assign static_fwd[slc_pkg::SLC_STATIC_LINK[g]] = q_r.stc[g];
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_halt_origin_one: assert property (halt_evt.core_one && !halt_evt.core_zero |=> debug_origin == 2'b10)
        else $error("core one halt not recorded");
    a_status_dest_read: assert property (q_r.a_rd && q_r.a_idx == slc_pkg::SLC_IDX_LSTAT |=>
        hreadyout && hrdata[23:16] == $past(link_stat[0].dest) && hrdata[1] == $past(link_stat[0].dst_busy))
        else $error("link status read wrong");
    a_processor_link_no_dir: assert property (q_r.a_rd && q_r.a_idx == slc_pkg::SLC_IDX_PSTAT |=> hrdata[15:6] == '0)
        else $error("processor link reserved bits set");
    a_link_enable_wr: assert property (wr_ok && q_r.a_idx == slc_pkg::SLC_IDX_LCFG |=>
        link_ctl[0].en == $past(hwdata[31]) && link_ctl[0].sym_gap == $past(hwdata[21:11]))
        else $error("link config write lost");
    a_error_sticky: assert property (link_evt[0].ovf |=> q_r.cfg[0].err [*2] or (q_r.cfg[0].err ##1 $past(cmd_rxrst[0])))
        else $error("error flag not held");
    a_credit_grant: assert property (link_evt[0].cred_in |=> q_r.cfg[0].held)
        else $error("credit grant lost");
    a_link_greeting_token_clears: assert property (cmd_link_greeting_token[0] && !link_evt[0].cred_in |=> !q_r.cfg[0].held && link_link_greeting_token[0])
        else $error("greeting did not clear credit");
    a_rx_reset_pulse: assert property (link_rx_reset != '0 |-> $past(cmd_rxrst) == link_rx_reset)
        else $error("receiver reset without command");
    a_link_greeting_token_one_cycle: assert property (link_link_greeting_token[0] && !cmd_link_greeting_token[0] |=> !link_link_greeting_token[0])
        else $error("greeting pulse too long");
    a_static_order: assert property (wr_ok && q_r.a_idx == slc_pkg::SLC_IDX_STAT |=>
        static_fwd[2].en == $past(hwdata[31]) && static_fwd[2].chanend == $past(hwdata[4:0]))
        else $error("static register mapped to wrong link");
    // static register 3 drives link letter B
    a_lock_blocks: assert property (q_r.lock && q_r.a_wr && q_r.a_idx == slc_pkg::SLC_IDX_STAT + 8'h03 |=>
        $stable(static_fwd[1]))
        else $error("locked write took effect");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    c_read_status: cover property (q_r.a_rd && q_r.a_idx == slc_pkg::SLC_IDX_LSTAT);
    c_link_greeting_token_sent:  cover property (link_link_greeting_token[0] ##[1:20] q_r.cfg[0].held);
    c_locked_wr:   cover property (q_r.lock && q_r.a_wr);
    c_halt_event:  cover property (halt_evt.core_zero);

endmodule

/* File: design/slc_pkg.sv */
// package of constants and carrier types for the switch link control registers
package slc_pkg;

    // ------------------------------------------------------------------
    // sizes and register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam int unsigned SLC_LINKS      = 8;       // links per register group
    localparam logic [7:0]  SLC_IDX_LOCK   = 8'h04;   // switch configuration, holds write lock
    localparam logic [7:0]  SLC_IDX_DBG    = 8'h1f;   // debug event origin
    localparam logic [7:0]  SLC_IDX_LSTAT  = 8'h20;   // link status, direction, network
    localparam logic [7:0]  SLC_IDX_PSTAT  = 8'h40;   // processor link status and network
    localparam logic [7:0]  SLC_IDX_LCFG   = 8'h80;   // external link configuration
    localparam logic [7:0]  SLC_IDX_STAT   = 8'ha0;   // static forwarding configuration

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SLC_LOCK_BIT  = 31;  // write lock
    localparam int SLC_KIND_LSB  = 24;  // source target kind, 25:24
    localparam int SLC_DEST_LSB  = 16;  // destination link, 23:16
    localparam int SLC_DIR_LSB   = 8;   // direction, 11:8
    localparam int SLC_NET_LSB   = 4;   // network, 5:4
    localparam int SLC_JUNK_BIT  = 2;
    localparam int SLC_DBUSY_BIT = 1;
    localparam int SLC_SBUSY_BIT = 0;
    localparam int SLC_EN_BIT    = 31;  // link enable
    localparam int SLC_FIVE_BIT  = 30;  // five-wire mode
    localparam int SLC_ERR_BIT   = 27;
    localparam int SLC_ISS_BIT   = 26;  // credit issued
    localparam int SLC_HELD_BIT  = 25;  // credit held
    localparam int SLC_LINK_GREETING_TOKEN_BIT = 24;  // command: greeting token
    localparam int SLC_RXRST_BIT = 23;  // command: receiver reset
    localparam int SLC_SYM_LSB   = 11;  // symbol gap, 21:11
    localparam int SLC_TOK_LSB   = 0;   // token gap, 10:0
    localparam int SLC_SEN_BIT   = 31;  // static enable
    localparam int SLC_PROC_BIT  = 8;   // static destination processor
    localparam int SLC_CHE_LSB   = 0;   // static channel end, 4:0

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] SLC_RD_RESET = 32'h0000_0000;

    // static register n drives link letter SLC_STATIC_LINK[n] (A=0 .. H=7)
    localparam logic [2:0] SLC_STATIC_LINK [SLC_LINKS] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {             // live status from one link
        logic [1:0] src_kind;           // 0 switch_link, 1 processor_link, 2 switch_control_port
        logic [7:0] dest;               // destination link number
        logic       junk;               // current packet judged junk
        logic       dst_busy;
        logic       src_busy;
    } slc_lstat_t;

    typedef struct packed {             // one-cycle events from an external link
        logic ovf;                      // receive buffer overflow
        logic bad_tok;                  // illegal token encoding
        logic cred_in;                  // remote end granted us credit
        logic cred_out;                 // we issued credit to the remote end
    } slc_levt_t;

    typedef struct packed {             // stored external link configuration
        logic        en;
        logic        five;
        logic        err;
        logic        issued;
        logic        held;
        logic [10:0] sym_gap;
        logic [10:0] tok_gap;
    } slc_lcfg_t;

    typedef struct packed {             // controls to an external link
        logic        en;
        logic        five;
        logic [3:0]  dir;
        logic [1:0]  net;
        logic [10:0] sym_gap;
        logic [10:0] tok_gap;
    } slc_lctl_t;

    typedef struct packed {             // static forwarding of one link
        logic       en;
        logic       proc;
        logic [4:0] chanend;
    } slc_static_t;

    typedef struct packed {             // global halt event pulses
        logic core_one;
        logic core_zero;
    } slc_halt_t;

    typedef struct packed {             // whole block state
        logic [1:0]                    dbg;
        logic                          lock;
        logic [SLC_LINKS-1:0][3:0]     dir;
        logic [SLC_LINKS-1:0][1:0]     lnet;
        logic [SLC_LINKS-1:0][1:0]     pnet;
        slc_lcfg_t [SLC_LINKS-1:0]     cfg;
        slc_static_t [SLC_LINKS-1:0]   stc;
        logic [SLC_LINKS-1:0]          link_greeting_token;
        logic [SLC_LINKS-1:0]          rx_rst;
        logic [7:0]                    a_idx;
        logic                          a_wr;
        logic                          a_rd;
        logic                          hready;
        logic [31:0]                   hrdata;
    } slc_state_t;

endpackage

/* File: test/slc_far_end.sv */
// behavioural remote switch at the far end of each external link
`timescale 1ns/1ps
module slc_far_end (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic [7:0]                             link_greeting_token,
    input  wire logic [7:0]                             err_req,
    input  wire logic [3:0]                             dly,
    output slc_pkg::slc_levt_t [slc_pkg::SLC_LINKS-1:0] evt
);
    logic [3:0] cnt [8];    // cycles left before the credit answer
    // a greeting is answered with credit after dly cycles; dly 0 never answers
    always_ff @(posedge clk or negedge rst_n) begin
        for (int i = 0; i < 8; i++) begin
            if (!rst_n) begin
                cnt[i] <= 4'h0;
                evt[i] <= '0;
            end else begin
                evt[i].ovf      <= err_req[i] & ~i[0];
                evt[i].bad_tok  <= err_req[i] & i[0];
                evt[i].cred_in  <= (cnt[i] == 4'h1);
                evt[i].cred_out <= (cnt[i] == 4'h1);
                cnt[i]          <= link_greeting_token[i] ? dly : (cnt[i] != 4'h0 ? cnt[i] - 4'h1 : 4'h0);
            end
        end
    end
endmodule

/* File: test/switch_link_control_regs_tb.sv */
// self-checking bench for the switch link control registers
`timescale 1ns/1ps
module switch_link_control_regs_tb;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans, dbg;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] link_greeting_token, rxr, err_req;
    logic [3:0] dly;
    logic [7:0][1:0] pn;
    slc_pkg::slc_halt_t halt;
    slc_pkg::slc_lstat_t [7:0] ls, ps;
    slc_pkg::slc_levt_t [7:0] evt;
    slc_pkg::slc_lctl_t [7:0] ctl;
    slc_pkg::slc_static_t [7:0] sf;
    logic [31:0] mdl [256];             // reference register contents
    int num_errors = 0, samples_checked = 0, cyc = 0, seed = 32'hb9a3;
    int lt [8] = '{2, 3, 0, 1, 6, 7, 4, 5};    // link letter per static register
    int rxn [8], rxe [8], hln [8], hle [8];     // command pulses seen and expected per link

    slc_regs u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .halt_evt(halt), .debug_origin(dbg), .link_stat(ls), .processor_link_stat(ps),
        .link_evt(evt), .link_ctl(ctl), .processor_link_net(pn), .link_link_greeting_token(link_greeting_token), .link_rx_reset(rxr),
        .static_fwd(sf));
    slc_far_end u_far (.clk(clk), .rst_n(rst_n), .link_greeting_token(link_greeting_token), .err_req(err_req), .dly(dly), .evt(evt));

    // writable bits per word index
    function automatic logic [31:0] wmask(input logic [7:0] x);
        if (x == 8'h04) return 32'h8000_0000;
        if (x == 8'h1f) return 32'h3;
        case (x[7:3])
            5'h04: return 32'hf30;
            5'h08: return 32'h30;
            5'h10: return 32'hc03f_ffff;
            5'h14: return 32'h8000_011f;
            default: return 32'h0;
        endcase
    endfunction
    // live status fields of link and processor link words
    function automatic logic [31:0] live(input logic [7:0] x);
        logic [12:0] s;
        s = x[6] ? ps[x[2:0]] : ls[x[2:0]];
        if (x[7:3] != 5'h04 && x[7:3] != 5'h08) return 32'h0;
        return {6'h0, s[12:3], 13'h0, s[2:0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // one ahb single transfer; the model follows each write
    task automatic xfer(input logic w, input logic [7:0] x, input logic [31:0] v);
        logic [31:0] o;
        @(posedge clk);
        hsel <= 1'b1; haddr <= {22'h0, x, 2'b00}; htrans <= 2'h2; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= v;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        o = mdl[x] & 32'h0e00_0000;
        if (!v[31]) o &= ~32'h0600_0000;
        if (v[23]) o &= ~32'h0c00_0000;
        if (v[24]) o &= ~32'h0200_0000;
        if (w && !mdl[4][31] && x[7:3] == 5'h10) begin
            rxe[x[2:0]] += v[23];
            hle[x[2:0]] += v[24];
        end
        if (w && (!mdl[4][31] || x == 8'h04)) mdl[x] = (v & wmask(x)) | (x[7:3] == 5'h10 ? o : 32'h0);
    endtask
    // count every cycle a command pulse stands, so a long pulse shows up
    always @(posedge clk) begin
        for (int k = 0; k < 8; k++) begin
            rxn[k] += rxr[k];
            hln[k] += link_greeting_token[k];
        end
    end
    task automatic rchk(input logic [7:0] x);
        xfer(1'b0, x, 32'h0);
        chk("read", mdl[x] | live(x), rd);
    endtask
    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
        halt = '0; err_req = '0; dly = 4'h1; ls = '0; ps = '0;
        foreach (mdl[k]) mdl[k] = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int j = 0; j < 8; j++) begin
            ls[j] <= 13'($random(seed));
            ps[j] <= 13'($random(seed));
        end
        foreach (lt[j]) rchk(8'h80 + 8'(j));
        xfer(1'b1, 8'h3f, 32'hffff_ffff);
        rchk(8'h3f);
        xfer(1'b1, 8'h1f, $random(seed));
        rchk(8'h1f);
        @(posedge clk) halt <= 2'b10;
        @(posedge clk) halt <= 2'b01;
        @(posedge clk) halt <= 2'b00;
        mdl[8'h1f] = 32'h1;
        rchk(8'h1f);
        chk("origin", mdl[8'h1f], {30'h0, dbg});
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 8'h20 + 8'(i), $random(seed));
            rchk(8'h20 + 8'(i));
            chk("dir_net", {mdl[8'h20 + i][11:8], mdl[8'h20 + i][5:4]}, {ctl[i].dir, ctl[i].net});
            xfer(1'b1, 8'h40 + 8'(i), $random(seed));
            rchk(8'h40 + 8'(i));
            chk("pnet", {30'h0, mdl[8'h40 + i][5:4]}, {30'h0, pn[i]});
            // greeting kept out here: its credit answer is timed further down
            xfer(1'b1, 8'h80 + 8'(i), $random(seed) & 32'hfeff_ffff);
            rchk(8'h80 + 8'(i));
            chk("ctl", {mdl[8'h80 + i][31:30], mdl[8'h80 + i][21:0]},
                {ctl[i].en, ctl[i].five, ctl[i].sym_gap, ctl[i].tok_gap});
            dly <= i[0] ? 4'h9 : 4'h1;
            xfer(1'b1, 8'h80 + 8'(i), 32'h8100_0000);
            do @(posedge clk); while (evt[i].cred_in !== 1'b1);
            mdl[8'h80 + i] |= 32'h0600_0000;
            rchk(8'h80 + 8'(i));
            @(posedge clk) err_req <= 8'(1 << i);
            @(posedge clk) err_req <= 8'h0;
            mdl[8'h80 + i] |= 32'h0800_0000;
            rchk(8'h80 + 8'(i));
            xfer(1'b1, 8'h80 + 8'(i), 32'h8080_0000);
            rchk(8'h80 + 8'(i));
            chk("rx_reset", rxe[i], rxn[i]);
            chk("link_greeting_token", hle[i], hln[i]);
            xfer(1'b1, 8'ha0 + 8'(i), $random(seed));
            rchk(8'ha0 + 8'(i));
            chk("fwd", {mdl[8'ha0 + i][31], mdl[8'ha0 + i][8], mdl[8'ha0 + i][4:0]}, sf[lt[i]]);
        end
        xfer(1'b1, 8'h04, 32'h8000_0000);
        xfer(1'b1, 8'ha3, 32'hffff_ffff);
        chk("hresp", 32'h0, {31'h0, hresp});
        rchk(8'ha3);
        xfer(1'b1, 8'h04, 32'h0);
        rchk(8'h04);
        conclude();
    end
endmodule
